// ===== shared/dcas_pkg.sv
/*
 * dcas_pkg: constants and types shared by the dma channel address and status block.
 * assumes a 16-bit register port with word-indexed addresses and eight channels.
 */
`default_nettype none
package dcas_pkg;

    // sizes
    localparam int NUM_CH   = 8;
    localparam int DATA_W   = 16;
    localparam int ADDR_W   = 6;
    localparam int LEN_W    = 10;
    localparam int CHIDX_W  = 3;
    localparam int LAST_W   = 4;
    localparam int IRQ_W    = 9;

    // register map: channel window is {1'b0, channel[2:0], reg[1:0]}
    localparam int          CHWIN_BIT   = 5;
    localparam int          CHSEL_LSB   = 2;
    localparam logic [1:0]  REG_PRI     = 2'h0;
    localparam logic [1:0]  REG_SEC     = 2'h1;
    localparam logic [1:0]  REG_PER     = 2'h2;
    localparam logic [1:0]  REG_LEN     = 2'h3;
    localparam logic [5:0]  OFS_CLASH   = 6'h20;
    localparam logic [5:0]  OFS_HIST    = 6'h21;
    localparam logic [5:0]  OFS_IRQ_STS = 6'h22;
    localparam logic [5:0]  OFS_IRQ_MSK = 6'h23;

    // field positions
    localparam int CLASH_PER_LSB = 8;
    localparam int CLASH_RAM_LSB = 0;
    localparam int HIST_LAST_LSB = 8;
    localparam int HIST_PP_LSB   = 0;
    localparam int IRQ_DONE_LSB  = 0;
    localparam int IRQ_CLASH_BIT = 8;

    // reset values and codes
    localparam logic [15:0]       ZERO16       = 16'h0000;
    localparam logic [LEN_W-1:0]  LEN_ZERO     = 10'h000;
    localparam logic [LAST_W-1:0] LAST_NONE    = 4'hF;
    localparam logic [LAST_W-1:0] LAST_MAX_CH  = 4'h7;
    localparam logic [15:0]       ADDR_STEP    = 16'h0002;

    // channel sequencer states
    typedef enum logic [1:0] {
        DCAS_IDLE = 2'b00,
        DCAS_RUN  = 2'b01
    } dcas_ch_state_t;

endpackage
`default_nettype wire

// ===== hdl/dcas_chan.sv
/*
 * dcas_chan: one channel's buffer bases, peripheral address, length and block sequencer.
 * assumes one-cycle transfer pulses from the channel control logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module dcas_chan
    import dcas_pkg::*;
(
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // register writes
    input  wire logic              wr_i,
    input  wire logic [1:0]        sel_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    // channel control
    input  wire logic              chan_on_i,
    input  wire logic              pingpong_i,
    input  wire logic              xfer_i,
    // state out
    output logic [DATA_W-1:0]      pri_o,
    output logic [DATA_W-1:0]      sec_o,
    output logic [DATA_W-1:0]      per_o,
    output logic [LEN_W-1:0]       len_o,
    output logic [DATA_W-1:0]      ram_addr_o,
    output logic                   pp_sel_o,
    output logic                   done_o
);

    logic [DATA_W-1:0] pri_r, pri_nxt, sec_r, sec_nxt, per_r, per_nxt, ram_r, ram_nxt;
    logic [LEN_W-1:0]  len_r, len_nxt, idx_r, idx_nxt;
    logic              pp_r, pp_nxt, done_r, done_nxt;
    dcas_ch_state_t    st_r, st_nxt;

    // software-written registers
    always_comb begin
        pri_nxt = pri_r;
        sec_nxt = sec_r;
        per_nxt = per_r;
        len_nxt = len_r;
        if (wr_i) begin
            unique case (sel_i)
                REG_PRI: pri_nxt = wdata_i;
                REG_SEC: sec_nxt = wdata_i;
                REG_PER: per_nxt = wdata_i;
                REG_LEN: len_nxt = wdata_i[LEN_W-1:0];
            endcase
        end
    end

    // block sequencer: counts transfers, reloads base, swaps buffers
    always_comb begin
        st_nxt   = st_r;
        idx_nxt  = idx_r;
        pp_nxt   = pp_r;
        ram_nxt  = ram_r;
        done_nxt = 1'b0;
        unique case (st_r)
            DCAS_IDLE: begin
                idx_nxt = LEN_ZERO;
                ram_nxt = pp_r ? sec_r : pri_r;
                if (chan_on_i) begin
                    st_nxt = DCAS_RUN;
                end
            end
            DCAS_RUN: begin
                if (!chan_on_i) begin
                    st_nxt = DCAS_IDLE;
                end else if (xfer_i) begin
                    if (idx_r == len_r) begin
                        done_nxt = 1'b1;
                        idx_nxt  = LEN_ZERO;
                        pp_nxt   = pingpong_i ? ~pp_r : pp_r;
                        ram_nxt  = pp_nxt ? sec_r : pri_r;
                    end else begin
                        idx_nxt = idx_r + 10'h001;
                        ram_nxt = ram_r + ADDR_STEP;
                    end
                end
            end
        endcase
    end

    // registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pri_r  <= ZERO16;
            sec_r  <= ZERO16;
            per_r  <= ZERO16;
            len_r  <= LEN_ZERO;
            st_r   <= DCAS_IDLE;
            idx_r  <= LEN_ZERO;
            pp_r   <= 1'b0;
            ram_r  <= ZERO16;
            done_r <= 1'b0;
        end else begin
            pri_r  <= pri_nxt;
            sec_r  <= sec_nxt;
            per_r  <= per_nxt;
            len_r  <= len_nxt;
            st_r   <= st_nxt;
            idx_r  <= idx_nxt;
            pp_r   <= pp_nxt;
            ram_r  <= ram_nxt;
            done_r <= done_nxt;
        end
    end

    assign pri_o      = pri_r;
    assign sec_o      = sec_r;
    assign per_o      = per_r;
    assign len_o      = len_r;
    assign ram_addr_o = ram_r;
    assign pp_sel_o   = pp_r;
    assign done_o     = done_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // a block end in ping-pong mode flips the buffer and reloads from the new base
    a_pp_swap: assert property (xfer_i && chan_on_i && st_r == DCAS_RUN && idx_r == len_r && pingpong_i
        |=> done_r && pp_r != $past(pp_r) && ram_r == (pp_r ? $past(sec_r) : $past(pri_r)))
        else $error("ping-pong swap or reload missing");
    // without ping-pong the same base is reloaded
    a_base_reload: assert property (xfer_i && chan_on_i && st_r == DCAS_RUN && idx_r == len_r && !pingpong_i
        |=> done_r && $stable(pp_r) && ram_r == (pp_r ? $past(sec_r) : $past(pri_r)))
        else $error("continuous reload wrong");
    // a mid-block transfer never ends the block
    a_mid_block: assert property (xfer_i && chan_on_i && st_r == DCAS_RUN && idx_r != len_r
        |=> !done_r && idx_r == $past(idx_r) + 10'h001)
        else $error("block ended early");

endmodule
`default_nettype wire

// ===== hdl/dcas_top.sv
/*
 * dcas_top: per-channel address and length registers plus shared status of an
 * eight-channel dma controller, with a plain register port and one interrupt.
 * assumes channel control, request selection and transfers live outside on the
 * same clock; transfer and clash inputs are one-cycle pulses.
 */
// Summary of operation
// - each channel holds a 16-bit primary ram base, writable, zero at reset
// - each channel holds a 16-bit secondary ram base, writable, zero at reset
// - each channel holds a 16-bit peripheral address, writable, zero at reset
// - 10-bit length field; a block is the field value plus one transfers
// - upper six length bits are unimplemented and read zero
// - per-channel peripheral clash flags in bits 15..8, sticky, software cleared
// - per-channel ram clash flags in bits 7..0, sticky, software cleared
// - last active channel field in bits 11..8 resets to all ones
// - each cycle with transfers records the highest pulsing channel number 0..7; codes 8..14 never appear
// - per-channel buffer select flag in bits 7..0: one means secondary base
// - in ping-pong mode successive blocks alternate primary and secondary bases
// - in continuous mode the base reloads after every block
`timescale 1ns/1ps
`default_nettype none
module dcas_top
    import dcas_pkg::*;
(
    // clock and reset
    input  wire logic                     SYS_CLK_I,
    input  wire logic                     RST_I,
    // register port
    input  wire logic [ADDR_W-1:0]        REG_ADDR_I,
    input  wire logic [DATA_W-1:0]        REG_WDATA_I,
    input  wire logic                     REG_WR_I,
    input  wire logic                     REG_RD_I,
    output logic [DATA_W-1:0]             REG_RDATA_O,
    // channel control from the controller
    input  wire logic [NUM_CH-1:0]        CH_ON_I,
    input  wire logic [NUM_CH-1:0]        CH_PINGPONG_I,
    input  wire logic [NUM_CH-1:0]        XFER_DONE_I,
    input  wire logic [NUM_CH-1:0]        PER_CLASH_I,
    input  wire logic [NUM_CH-1:0]        RAM_CLASH_I,
    // addresses and events to the transfer engine
    output logic [NUM_CH*DATA_W-1:0]      RAM_ADDR_O,
    output logic [NUM_CH*DATA_W-1:0]      PER_ADDR_O,
    output logic [NUM_CH-1:0]             BLOCK_DONE_O,
    output logic                          IRQ_O
);

    logic [DATA_W-1:0] pri_w [NUM_CH];
    logic [DATA_W-1:0] sec_w [NUM_CH];
    logic [DATA_W-1:0] per_w [NUM_CH];
    logic [LEN_W-1:0]  len_w [NUM_CH];
    logic [NUM_CH-1:0] pp_w;
    logic [NUM_CH-1:0] done_w;

    logic              ch_win;
    logic [CHIDX_W-1:0] ch_sel;

    // channel window decode
    assign ch_win = ~REG_ADDR_I[CHWIN_BIT];
    assign ch_sel = REG_ADDR_I[CHSEL_LSB +: CHIDX_W];

    // one sequencer per channel
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            dcas_chan u_chan (
                .clk_i      (SYS_CLK_I),
                .rst_i      (RST_I),
                .wr_i       (REG_WR_I && ch_win && ch_sel == CHIDX_W'(g)),
                .sel_i      (REG_ADDR_I[1:0]),
                .wdata_i    (REG_WDATA_I),
                .chan_on_i  (CH_ON_I[g]),
                .pingpong_i (CH_PINGPONG_I[g]),
                .xfer_i     (XFER_DONE_I[g]),
                .pri_o      (pri_w[g]),
                .sec_o      (sec_w[g]),
                .per_o      (per_w[g]),
                .len_o      (len_w[g]),
                .ram_addr_o (RAM_ADDR_O[g*DATA_W +: DATA_W]),
                .pp_sel_o   (pp_w[g]),
                .done_o     (done_w[g])
            );
            assign PER_ADDR_O[g*DATA_W +: DATA_W] = per_w[g];
        end
    endgenerate

    assign BLOCK_DONE_O = done_w;

    // shared status state
    logic [DATA_W-1:0] clash_r, clash_nxt;
    logic [LAST_W-1:0] last_r, last_nxt;
    logic [IRQ_W-1:0]  sts_r, sts_nxt, msk_r, msk_nxt;
    logic              irq_r, irq_nxt;
    logic              wr_clash, wr_sts, wr_msk;
    logic [DATA_W-1:0] clash_evt;
    logic [IRQ_W-1:0]  sts_evt;

    assign wr_clash  = REG_WR_I && REG_ADDR_I == OFS_CLASH;
    assign wr_sts    = REG_WR_I && REG_ADDR_I == OFS_IRQ_STS;
    assign wr_msk    = REG_WR_I && REG_ADDR_I == OFS_IRQ_MSK;
    assign clash_evt = {PER_CLASH_I, RAM_CLASH_I};
    assign sts_evt   = {|clash_evt, done_w};

    // sticky flags: a new event wins over a clear in the same cycle
    always_comb begin
        clash_nxt = (clash_r & ~(wr_clash ? REG_WDATA_I : ZERO16)) | clash_evt;
        sts_nxt   = (sts_r & ~(wr_sts ? REG_WDATA_I[IRQ_W-1:0] : {IRQ_W{1'b0}})) | sts_evt;
        msk_nxt   = wr_msk ? REG_WDATA_I[IRQ_W-1:0] : msk_r;
        irq_nxt   = |(sts_nxt & msk_nxt);
    end

    // last active channel: highest pulsing channel wins if several pulse
    always_comb begin
        last_nxt = last_r;
        for (int i = 0; i < NUM_CH; i++) begin
            if (XFER_DONE_I[i]) begin
                last_nxt = LAST_W'(i);
            end
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            clash_r <= ZERO16;
            last_r  <= LAST_NONE;
            sts_r   <= {IRQ_W{1'b0}};
            msk_r   <= {IRQ_W{1'b0}};
            irq_r   <= 1'b0;
        end else begin
            clash_r <= clash_nxt;
            last_r  <= last_nxt;
            sts_r   <= sts_nxt;
            msk_r   <= msk_nxt;
            irq_r   <= irq_nxt;
        end
    end

    assign IRQ_O = irq_r;

    // read data: valid only in the cycle after the read strobe
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic [DATA_W-1:0] hist_w;

    assign hist_w = {{(DATA_W-HIST_LAST_LSB-LAST_W){1'b0}}, last_r, pp_w};

    always_comb begin
        rdata_nxt = ZERO16;
        if (REG_RD_I) begin
            if (ch_win) begin
                unique case (REG_ADDR_I[1:0])
                    REG_PRI: rdata_nxt = pri_w[ch_sel];
                    REG_SEC: rdata_nxt = sec_w[ch_sel];
                    REG_PER: rdata_nxt = per_w[ch_sel];
                    REG_LEN: rdata_nxt = {{(DATA_W-LEN_W){1'b0}}, len_w[ch_sel]};
                endcase
            end else begin
                unique case (REG_ADDR_I)
                    OFS_CLASH:   rdata_nxt = clash_r;
                    OFS_HIST:    rdata_nxt = hist_w;
                    OFS_IRQ_STS: rdata_nxt = {{(DATA_W-IRQ_W){1'b0}}, sts_r};
                    OFS_IRQ_MSK: rdata_nxt = {{(DATA_W-IRQ_W){1'b0}}, msk_r};
                    default:     rdata_nxt = ZERO16;      // unmapped reads as zero
                endcase
            end
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            rdata_r <= ZERO16;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign REG_RDATA_O = rdata_r;

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);

    // helper: an event on this bit sets its flag the next cycle
    sequence s_clash_set(int b);
        clash_evt[b] ##1 clash_r[b];
    endsequence

    // a clash flag, once set, holds until software writes a one to it
    a_clash_sticky: assert property (clash_r[CLASH_PER_LSB] && !(wr_clash && REG_WDATA_I[CLASH_PER_LSB])
        |=> clash_r[CLASH_PER_LSB])
        else $error("peripheral clash flag lost without clear");
    // a ram clash arriving with its clear still sets the flag
    a_ram_clash_win: assert property (RAM_CLASH_I[0] && wr_clash && REG_WDATA_I[CLASH_RAM_LSB]
        |-> s_clash_set(CLASH_RAM_LSB))
        else $error("ram clash lost to a clear");
    // flags rise only from an event
    a_clash_cause: assert property ($rose(clash_r[CLASH_RAM_LSB]) |-> $past(RAM_CLASH_I[0]))
        else $error("ram clash flag set without event");
    // last channel shows none until the first transfer
    a_last_none: assert property (last_r != LAST_NONE |-> $past(last_r) != LAST_NONE || $past(|XFER_DONE_I))
        else $error("last channel left none without a transfer");
    // a lone channel 7 transfer records its channel next cycle, never a reserved code
    a_last_update: assert property (XFER_DONE_I == 8'h80 |=> last_r == LAST_MAX_CH)
        else $error("last channel not recorded");
    a_last_legal: assert property (last_r <= LAST_MAX_CH || last_r == LAST_NONE)
        else $error("reserved last channel code");
    // length readback keeps the top six bits clear
    a_len_upper: assert property (REG_RD_I && ch_win && REG_ADDR_I[1:0] == REG_LEN
        |=> REG_RDATA_O[DATA_W-1:LEN_W] == 6'h00 && REG_RDATA_O[LEN_W-1:0] == $past(len_w[ch_sel]))
        else $error("length readback wrong");
    // history readback mirrors buffer select flags
    a_pp_read: assert property (REG_RD_I && REG_ADDR_I == OFS_HIST
        |=> REG_RDATA_O[HIST_PP_LSB +: NUM_CH] == $past(pp_w))
        else $error("buffer select readback wrong");
    // a primary base write reads back through the port
    a_pri_write: assert property (REG_WR_I && ch_win && REG_ADDR_I[1:0] == REG_PRI ##1 REG_RD_I
        && REG_ADDR_I == $past(REG_ADDR_I) |=> REG_RDATA_O == $past(REG_WDATA_I, 2))
        else $error("primary base write not held");
    // read data only in the cycle after a read
    a_rdata_idle: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == ZERO16)
        else $error("read data outside its cycle");
    // interrupt follows unmasked status
    a_irq_level: assert property (IRQ_O == |(sts_r & msk_r))
        else $error("interrupt does not track status");

    // register writes land in the addressed channel one cycle later

    // primary base takes the written word
    a_pri_hold: assert property (REG_WR_I && ch_win && REG_ADDR_I[1:0] == REG_PRI
        |=> pri_w[$past(ch_sel)] == $past(REG_WDATA_I))
        else $error("primary base not written");

    // secondary base takes the written word
    a_sec_hold: assert property (REG_WR_I && ch_win && REG_ADDR_I[1:0] == REG_SEC
        |=> sec_w[$past(ch_sel)] == $past(REG_WDATA_I))
        else $error("secondary base not written");

    // peripheral address takes the written word
    a_per_hold: assert property (REG_WR_I && ch_win && REG_ADDR_I[1:0] == REG_PER
        |=> per_w[$past(ch_sel)] == $past(REG_WDATA_I))
        else $error("peripheral address not written");

    // length keeps only its ten low bits
    a_len_hold: assert property (REG_WR_I && ch_win && REG_ADDR_I[1:0] == REG_LEN
        |=> len_w[$past(ch_sel)] == $past(REG_WDATA_I[LEN_W-1:0]))
        else $error("length not written");

    // length holds while nothing is written
    a_len_keep: assert property (!REG_WR_I |=> len_w[0] == $past(len_w[0]))
        else $error("length changed without a write");

    // clash events and clears

    // a peripheral clash sets its flag
    a_per_set: assert property (PER_CLASH_I[0] |=> clash_r[CLASH_PER_LSB])
        else $error("peripheral clash not flagged");

    // a ram clash sets its flag
    a_ram_set: assert property (RAM_CLASH_I[7] |=> clash_r[CLASH_RAM_LSB + 7])
        else $error("ram clash not flagged");

    // a one written with no event clears the peripheral flag
    a_per_clear: assert property (wr_clash && REG_WDATA_I[CLASH_PER_LSB] && !PER_CLASH_I[0]
        |=> !clash_r[CLASH_PER_LSB])
        else $error("peripheral clash not cleared");

    // a one written with no event clears the ram flag
    a_ram_clear: assert property (wr_clash && REG_WDATA_I[CLASH_RAM_LSB] && !RAM_CLASH_I[0]
        |=> !clash_r[CLASH_RAM_LSB])
        else $error("ram clash not cleared");

    // clash readback mirrors the flags
    a_clash_read: assert property (REG_RD_I && REG_ADDR_I == OFS_CLASH
        |=> REG_RDATA_O == $past(clash_r))
        else $error("clash readback wrong");

    // history word

    // unused history bits read zero
    a_hist_upper: assert property (REG_RD_I && REG_ADDR_I == OFS_HIST
        |=> REG_RDATA_O[DATA_W-1:HIST_LAST_LSB+LAST_W] == 4'h0)
        else $error("history upper bits set");

    // last channel field reads back
    a_last_read: assert property (REG_RD_I && REG_ADDR_I == OFS_HIST
        |=> REG_RDATA_O[HIST_LAST_LSB +: LAST_W] == $past(last_r))
        else $error("last channel readback wrong");

    // channel zero alone records code zero
    a_last_low: assert property (XFER_DONE_I == 8'h01 |=> last_r == LAST_W'(0))
        else $error("channel zero not recorded");

    // interrupt status and mask

    // a mask write lands next cycle
    a_mask_write: assert property (wr_msk |=> msk_r == $past(REG_WDATA_I[IRQ_W-1:0]))
        else $error("mask not written");

    // a block end sets its status bit
    a_sts_done: assert property (done_w[0] |=> sts_r[IRQ_DONE_LSB])
        else $error("block end not in status");

    // any clash sets the shared status bit
    a_sts_clash: assert property (|clash_evt |=> sts_r[IRQ_CLASH_BIT])
        else $error("clash not in status");

endmodule
`default_nettype wire

// ===== sim/dcas_far_model.sv
/*
 * dcas_far_model: stands in for the transfer engine, peripherals and dma ram.
 * assumes one clock; emits one-cycle transfer and clash pulses as the bench asks.
 */
`timescale 1ns/1ps
`default_nettype none
module dcas_far_model
    import dcas_pkg::*;
(
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // bench commands
    input  wire logic              start_i,
    input  wire logic [2:0]        ch_i,
    input  wire logic [10:0]       cnt_i,
    input  wire logic              slow_i,
    input  wire logic [NUM_CH-1:0] pcl_i,
    input  wire logic [NUM_CH-1:0] rcl_i,
    // pulses towards the block
    output logic [NUM_CH-1:0]      xfer_o,
    output logic [NUM_CH-1:0]      pcl_o,
    output logic [NUM_CH-1:0]      rcl_o,
    output logic                   busy_o
);
    logic [10:0] left_r;
    logic [2:0]  ch_r;
    logic        ph_r;

    // one transfer a cycle, or every other cycle when slow
    always_ff @(posedge clk_i) begin
        xfer_o <= '0;
        pcl_o  <= pcl_i;
        rcl_o  <= rcl_i;
        ph_r   <= ~ph_r;
        if (rst_i) begin
            left_r <= '0;
            ch_r   <= '0;
            ph_r   <= 1'b0;
            pcl_o  <= '0;
            rcl_o  <= '0;
        end else if (start_i) begin
            left_r <= cnt_i;
            ch_r   <= ch_i;
        end else if (left_r != 11'h000 && (!slow_i || ph_r)) begin
            xfer_o[ch_r] <= 1'b1;
            left_r       <= left_r - 11'h001;
        end
    end

    assign busy_o = (left_r != 11'h000);
endmodule
`default_nettype wire

// ===== sim/test_dma_channel_address_status.sv
/*
 * test_dma_channel_address_status: random and corner-case bench for dcas_top.
 * assumes dcas_far_model drives the transfer and clash pulses.
 */
`timescale 1ns/1ps
`default_nettype none
module test_dma_channel_address_status;
    import dcas_pkg::*;
    logic        sys_clk, rst, wr, rd, irq, start, slow, busy;
    logic [5:0]  addr;
    logic [15:0] wdata, rdata, v, clash;
    logic [7:0]  ch_on, ch_pp, xfer, pcl, rcl, pcl_q, rcl_q, done, pp;
    logic [127:0] ram_addr, per_addr;
    logic [2:0]  mch;
    logic [10:0] mcnt;
    logic [15:0] pri [8];
    logic [15:0] sec [8];
    logic [15:0] per [8];
    logic [9:0]  len [8];
    int          n_errors, n_checks, seed, cyc;

    dcas_top uut (.SYS_CLK_I(sys_clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .CH_ON_I(ch_on), .CH_PINGPONG_I(ch_pp),
        .XFER_DONE_I(xfer), .PER_CLASH_I(pcl_q), .RAM_CLASH_I(rcl_q), .RAM_ADDR_O(ram_addr),
        .PER_ADDR_O(per_addr), .BLOCK_DONE_O(done), .IRQ_O(irq));
    dcas_far_model far (.clk_i(sys_clk), .rst_i(rst), .start_i(start), .ch_i(mch), .cnt_i(mcnt),
        .slow_i(slow), .pcl_i(pcl), .rcl_i(rcl), .xfer_o(xfer), .pcl_o(pcl_q), .rcl_o(rcl_q),
        .busy_o(busy));

    // clock and cycle ceiling
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            results();
        end
    end

    // expected ram base and history word
    function automatic logic [15:0] base(input int c);
        return pp[c] ? sec[c] : pri[c];
    endfunction
    function automatic logic [15:0] hist(input logic [2:0] c);
        return {5'h00, c, pp};
    endfunction

    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr_reg(input logic [5:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    // write then read back with no gap
    task wr_rd(input logic [5:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0; rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 chk(rdata, d);
    endtask
    task rd_chk(input logic [5:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        addr <= a; rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    // ask the far side for n transfers on channel c and wait until issued
    task run(input int c, input logic [10:0] n);
        @(posedge sys_clk);
        mch <= 3'(c); mcnt <= n; start <= 1'b1; slow <= 1'($random(seed));
        @(posedge sys_clk);
        start <= 1'b0;
        #1;
        while (busy) begin
            @(posedge sys_clk);
            #1;
        end
        @(posedge sys_clk);
        #1;
    endtask
    task results();
        if (n_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        seed = 89527; n_errors = 0; n_checks = 0; cyc = 0; rst = 1'b1; addr = '0; wdata = '0;
        wr = 1'b0; rd = 1'b0; ch_on = '0; ch_pp = '0; pcl = '0; rcl = '0; start = 1'b0;
        slow = 1'b0; mch = '0; mcnt = '0; pp = '0; clash = '0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        // reset values of the channel, clash and history registers
        for (int c = 0; c < 8; c++)
            for (int r = 0; r < 4; r++) rd_chk(6'(c * 4 + r), ZERO16);
        rd_chk(OFS_CLASH, ZERO16);
        rd_chk(OFS_HIST, 16'h0f00);
        // full length word, upper bits dropped
        wr_reg(6'h03, 16'hffff);
        rd_chk(6'h03, 16'h03ff);
        // random configuration while channels are off
        for (int c = 0; c < 8; c++) begin
            pri[c] = 16'($random(seed)); sec[c] = 16'($random(seed));
            per[c] = 16'($random(seed)); v = 16'($random(seed));
            len[c] = {8'h00, v[1:0]};
            wr_rd(6'(c * 4), pri[c]);
            wr_reg(6'(c * 4 + 1), sec[c]);
            wr_reg(6'(c * 4 + 2), per[c]);
            wr_reg(6'(c * 4 + 3), {v[15:10], 8'h00, v[1:0]});
            rd_chk(6'(c * 4), pri[c]);
            rd_chk(6'(c * 4 + 1), sec[c]);
            rd_chk(6'(c * 4 + 2), per[c]);
            rd_chk(6'(c * 4 + 3), {6'h00, len[c]});
            chk(per_addr[16 * c +: 16], per[c]);
        end
        wr_reg(6'h30, 16'hffff);
        rd_chk(6'h30, ZERO16);
        wr_reg(OFS_IRQ_MSK, 16'h01ff);
        @(posedge sys_clk);
        ch_pp <= 8'h55; ch_on <= 8'hff;
        @(posedge sys_clk);
        // two blocks per channel, ping-pong on even channels
        for (int b = 0; b < 2; b++)
            for (int c = 0; c < 8; c++) begin
                if (len[c] != 10'h000) begin
                    run(c, 11'(len[c]));
                    chk(ram_addr[16 * c +: 16], base(c) + 16'(2 * len[c]));
                    chk({8'h00, done}, ZERO16);
                end
                run(c, 11'h001);
                chk({8'h00, done}, 16'(1 << c));
                if (ch_pp[c]) pp[c] = ~pp[c];
                chk(ram_addr[16 * c +: 16], base(c));
                @(posedge sys_clk);
                #1 chk({15'h0000, irq}, 16'h0001);
                rd_chk(OFS_HIST, hist(3'(c)));
                wr_reg(OFS_IRQ_STS, 16'(1 << c));
                rd_chk(OFS_IRQ_STS, ZERO16);
                chk({15'h0000, irq}, ZERO16);
            end
        // clash flags land on their own bits and stay until cleared
        for (int k = 0; k < 8; k++) begin
            @(posedge sys_clk);
            pcl <= 8'(1 << k); rcl <= 8'(1 << (7 - k));
            @(posedge sys_clk);
            pcl <= '0; rcl <= '0;
            clash = clash | 16'(1 << (k + 8)) | 16'(1 << (7 - k));
            rd_chk(OFS_CLASH, clash);
        end
        chk({15'h0000, irq}, 16'h0001);
        wr_reg(OFS_IRQ_MSK, ZERO16);
        rd_chk(OFS_IRQ_STS, 16'h0100);
        chk({15'h0000, irq}, ZERO16);
        wr_reg(OFS_CLASH, 16'h00ff);
        rd_chk(OFS_CLASH, 16'hff00);
        // ram clash meets its own clear in one cycle: the set wins
        @(posedge sys_clk);
        rcl <= 8'h01; addr <= OFS_CLASH; wdata <= 16'h0001;
        @(posedge sys_clk);
        rcl <= '0; wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
        rd_chk(OFS_CLASH, 16'hff01);
        // second reset in mid-run
        @(posedge sys_clk);
        rst <= 1'b1;
        @(posedge sys_clk);
        rst <= 1'b0;
        pp = '0;
        rd_chk(OFS_HIST, 16'h0f00);
        rd_chk(OFS_CLASH, ZERO16);
        results();
    end
endmodule
`default_nettype wire
